// >>> rtl/bfsr_defs.vh
// Register offsets, field positions and reset values of the fault status bank
`ifndef BFSR_DEFS_VH
`define BFSR_DEFS_VH
`define BFSR_ADDR_W 8
`define BFSR_BOOST_OFS 8'h10
`define BFSR_LED_OFS 8'h12
`define BFSR_RESET_VAL 16'h0000
`define BFSR_THERMAL_FLAG 15
`define BFSR_THERMAL_ACK 14
`define BFSR_ISHORT_FLAG 13
`define BFSR_ISHORT_ACK 12
`define BFSR_STRRES_FLAG 11
`define BFSR_STRRES_ACK 10
`define BFSR_SELRES_FLAG 9
`define BFSR_SELRES_ACK 8
`define BFSR_FREQRES_FLAG 7
`define BFSR_FREQRES_ACK 6
`define BFSR_OCP_FLAG 5
`define BFSR_OCP_ACK 4
`define BFSR_OVPH_FLAG 3
`define BFSR_OVPH_ACK 2
`define BFSR_OVPL_FLAG 1
`define BFSR_OVPL_ACK 0
`define BFSR_BUSTMO_FLAG 14
`define BFSR_BUSTMO_ACK 13
`define BFSR_BADSTR_FLAG 12
`define BFSR_BADSTR_ACK 11
`define BFSR_CHAN_FLAG 10
`define BFSR_CHAN_ACK 9
`define BFSR_GND_FLAG 8
`define BFSR_SHORT_FLAG 7
`define BFSR_OPEN_FLAG 6
`define BFSR_CHANS 6
`endif

// >>> rtl/bfsr_regs.v
// Boost and LED fault status registers with paired write-one clear
// Functional notes
// - Boost fault register at offset 0x10, 16 bits, reads zero after reset.
// - LED fault register at offset 0x12, 16 bits, reads zero after reset.
// - Fault clears only when flag and ack bits both written one together.
// - Thermal shutdown flag bit 15, ack bit 14.
// - Current-set resistor short flag bit 13, ack bit 12.
// - Missing string resistor flag bit 11, ack bit 10.
// - Missing mode-select resistor flag bit 9, ack bit 8.
// - Missing frequency resistor flag bit 7, ack bit 6.
// - Boost over-current flag bit 5, ack bit 4.
// - Boost high over-voltage flag bit 3, ack bit 2.
// - Boost low over-voltage flag bit 1, ack bit 0; clears status only.
// - LED bit 15 reserved; bus timeout flag bit 14, ack bit 13.
// - Bad string configuration flag bit 12, ack bit 11.
// - Aggregate channel fault bit 10, ack 9; ground bit 8; channels bits 5..0.
// - Internal short bit 7, open bit 6; cleared with aggregate channel fault.
`timescale 1ns/1ps
`default_nettype none
`include "bfsr_defs.vh"
module bfsr_regs #(
    parameter CHANS = `BFSR_CHANS
) (
    input wire ref_clk,
    input wire sys_rst,
    input wire wr_en,
    input wire rd_en,
    input wire [`BFSR_ADDR_W-1:0] addr,
    input wire [15:0] wr_data,
    output reg [15:0] rd_data,
    output reg rd_hit,
    input wire thermal_trip_evt,
    input wire current_resistor_short_evt,
    input wire string_resistor_missing_evt,
    input wire select_resistor_missing_evt,
    input wire freq_resistor_missing_evt,
    input wire boost_overcurrent_evt,
    input wire boost_overvolt_high_evt,
    input wire boost_overvolt_low_evt,
    input wire bus_timeout_evt,
    input wire bad_string_config_evt,
    input wire channel_ground_short_evt,
    input wire channel_internal_short_evt,
    input wire channel_open_evt,
    input wire [CHANS-1:0] channel_fault_evt,
    output wire fault_irq_req
);

// ----------------------------------------------------------------
// Flag storage
// ----------------------------------------------------------------
reg [7:0] boost_flags;
reg bus_timeout_flag;
reg bad_string_config_flag;
reg channel_fault_agg;
reg channel_ground_short_flag;
reg channel_internal_short_flag;
reg channel_open_flag;
reg [CHANS-1:0] channel_fault_flags;
// Channel detail flags have no clear pair of their own; the aggregate pair clears them

// ----------------------------------------------------------------
// Address decode
// ----------------------------------------------------------------
// One decode feeds both paths, so a write and a read at one offset always agree
function [1:0] reg_select;
    input [`BFSR_ADDR_W-1:0] offset;
    begin
        reg_select = 2'h0;
        if (offset == `BFSR_BOOST_OFS) begin
            reg_select = 2'h1;
        end else if (offset == `BFSR_LED_OFS) begin
            reg_select = 2'h2;
        end
    end
endfunction

wire [1:0] addr_sel = reg_select(addr);
wire wr_boost = wr_en & addr_sel[0];
wire wr_led = wr_en & addr_sel[1];
wire rd_boost = rd_en & addr_sel[0];
wire rd_led = rd_en & addr_sel[1];

// True when the flag bit and its ack bit are both one in the written word
function pair_clear;
    input [15:0] data;
    input integer flag_pos;
    begin
        pair_clear = data[flag_pos] & data[flag_pos-1];
    end
endfunction

// ----------------------------------------------------------------
// Boost fault events, flag k at bit 2k+1 and its ack at bit 2k
// ----------------------------------------------------------------
wire [7:0] boost_evt = {
    thermal_trip_evt,
    current_resistor_short_evt,
    string_resistor_missing_evt,
    select_resistor_missing_evt,
    freq_resistor_missing_evt,
    boost_overcurrent_evt,
    boost_overvolt_high_evt,
    boost_overvolt_low_evt
};

// ----------------------------------------------------------------
// Boost flags, one per bit pair
// ----------------------------------------------------------------
wire [7:0] next_boost_flags;
genvar k;
generate
    for (k = 0; k < 8; k = k + 1) begin : g_boost
        // A new event beats a clear in the same cycle, so no fault is lost
        assign next_boost_flags[k] = boost_evt[k] |
            (boost_flags[k] & ~(wr_boost & pair_clear(wr_data, 2 * k + 1)));
    end
endgenerate

always @(posedge ref_clk) begin
    if (sys_rst) begin
        boost_flags <= 8'h00;
    end else begin
        boost_flags <= next_boost_flags;
    end
end

wire clr_chan = wr_led && pair_clear(wr_data, `BFSR_CHAN_FLAG);
wire any_chan_evt = channel_ground_short_evt | channel_internal_short_evt |
    channel_open_evt | (|channel_fault_evt);

// ----------------------------------------------------------------
// LED flags
// ----------------------------------------------------------------
always @(posedge ref_clk) begin
    if (sys_rst) begin
        bus_timeout_flag <= 1'b0;
        bad_string_config_flag <= 1'b0;
        channel_fault_agg <= 1'b0;
        channel_ground_short_flag <= 1'b0;
        channel_internal_short_flag <= 1'b0;
        channel_open_flag <= 1'b0;
        channel_fault_flags <= {CHANS{1'b0}};
    end else begin
        if (bus_timeout_evt) begin
            bus_timeout_flag <= 1'b1;
        end else if (wr_led && pair_clear(wr_data, `BFSR_BUSTMO_FLAG)) begin
            bus_timeout_flag <= 1'b0;
        end
        if (bad_string_config_evt) begin
            bad_string_config_flag <= 1'b1;
        end else if (wr_led && pair_clear(wr_data, `BFSR_BADSTR_FLAG)) begin
            bad_string_config_flag <= 1'b0;
        end
        if (any_chan_evt) begin
            channel_fault_agg <= 1'b1;
        end else if (clr_chan) begin
            channel_fault_agg <= 1'b0;
        end
        // Detail flags follow the aggregate's clear; set still wins
        if (channel_ground_short_evt) begin
            channel_ground_short_flag <= 1'b1;
        end else if (clr_chan) begin
            channel_ground_short_flag <= 1'b0;
        end
        if (channel_internal_short_evt) begin
            channel_internal_short_flag <= 1'b1;
        end else if (clr_chan) begin
            channel_internal_short_flag <= 1'b0;
        end
        if (channel_open_evt) begin
            channel_open_flag <= 1'b1;
        end else if (clr_chan) begin
            channel_open_flag <= 1'b0;
        end
        channel_fault_flags <= channel_fault_evt |
            (clr_chan ? {CHANS{1'b0}} : channel_fault_flags);
    end
end

// ----------------------------------------------------------------
// Read path and interrupt request
// ----------------------------------------------------------------
wire [15:0] boost_word = {boost_flags[7], 1'b0, boost_flags[6], 1'b0,
    boost_flags[5], 1'b0, boost_flags[4], 1'b0, boost_flags[3], 1'b0,
    boost_flags[2], 1'b0, boost_flags[1], 1'b0, boost_flags[0], 1'b0};
// Ack bits always read back as zero; only the flags are stored
wire [15:0] led_word = {
    1'b0,
    bus_timeout_flag,
    1'b0,
    bad_string_config_flag,
    1'b0,
    channel_fault_agg,
    1'b0,
    channel_ground_short_flag,
    channel_internal_short_flag,
    channel_open_flag,
    channel_fault_flags
};

always @(posedge ref_clk) begin
    if (sys_rst) begin
        rd_data <= `BFSR_RESET_VAL;
        rd_hit <= 1'b0;
    end else begin
        // Unmapped offsets answer zero with no hit
        rd_hit <= rd_boost | rd_led;
        if (rd_boost) begin
            rd_data <= boost_word;
        end else if (rd_led) begin
            rd_data <= led_word;
        end else begin
            rd_data <= `BFSR_RESET_VAL;
        end
    end
end

// Low over-voltage flag stays off the pin: its clear only touches status
// Read-only detail flags reach the pin only through the aggregate flag
assign fault_irq_req = (|boost_flags[7:1]) | bus_timeout_flag |
    bad_string_config_flag | channel_fault_agg;

endmodule // bfsr_regs
`default_nettype wire

// >>> tb/bfsr_asserts.sv
// Concurrent checks on the fault status bank ports
`timescale 1ns/1ps
`default_nettype none
module bfsr_asserts #(
    parameter CHANS = 6
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic rd_en,
    input wire logic [7:0] addr,
    input wire logic [15:0] rd_data,
    input wire logic rd_hit,
    input wire logic thermal_trip_evt,
    input wire logic [CHANS-1:0] channel_fault_evt,
    input wire logic fault_irq_req
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    chk_rd_mapped: assert property (rd_en && (addr == 8'h10 || addr == 8'h12) |=> rd_hit)
        else $error("mapped read without hit");
    chk_rd_unmapped: assert property (rd_en && addr != 8'h10 && addr != 8'h12
        |=> !rd_hit && rd_data == 16'h0000) else $error("unmapped read answered");
    chk_rd_idle: assert property (!rd_en |=> rd_data == 16'h0000 && !rd_hit)
        else $error("read data outside a read");
    chk_evt_irq: assert property (thermal_trip_evt |=> fault_irq_req)
        else $error("fault without interrupt request");
    chk_thermal_read: assert property (thermal_trip_evt ##2 (rd_en && addr == 8'h10)
        |=> rd_data[15]) else $error("thermal flag not read back");
    chk_chan_read: assert property (channel_fault_evt[0] ##2 (rd_en && addr == 8'h12)
        |=> rd_data[0] && rd_data[10]) else $error("channel flag not read back");
    chk_ack_zero: assert property (rd_hit && $past(addr) == 8'h10
        |-> (rd_data & 16'h5555) == 16'h0000) else $error("ack bit read as one");
    chk_resv_zero: assert property (rd_hit && $past(addr) == 8'h12 |-> !rd_data[15])
        else $error("reserved bit set");
    chk_irq_reset: assert property ($fell(sys_rst) |-> !fault_irq_req)
        else $error("interrupt request after reset");
endmodule // bfsr_asserts
`default_nettype wire

// >>> tb/testbench.sv
// Register-level bench for the fault status bank
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic ref_clk = 0, sys_rst = 1, wr_en = 0, rd_en = 0;
    logic [7:0] addr = 0, a;
    logic [15:0] wr_data = 0, m;
    logic [12:0] ev = 0;
    logic [5:0] chan = 0;
    wire [15:0] rd_data;
    wire rd_hit, fault_irq_req;
    integer num_errors = 0, samples_checked = 0, k, pos;
    always #5 ref_clk = ~ref_clk;
    bfsr_regs dut_u (.ref_clk(ref_clk), .sys_rst(sys_rst), .wr_en(wr_en), .rd_en(rd_en),
        .addr(addr), .wr_data(wr_data), .rd_data(rd_data), .rd_hit(rd_hit),
        .boost_overvolt_low_evt(ev[0]), .boost_overvolt_high_evt(ev[1]),
        .boost_overcurrent_evt(ev[2]), .freq_resistor_missing_evt(ev[3]),
        .select_resistor_missing_evt(ev[4]), .string_resistor_missing_evt(ev[5]),
        .current_resistor_short_evt(ev[6]), .thermal_trip_evt(ev[7]),
        .bus_timeout_evt(ev[8]), .bad_string_config_evt(ev[9]),
        .channel_ground_short_evt(ev[10]), .channel_internal_short_evt(ev[11]),
        .channel_open_evt(ev[12]), .channel_fault_evt(chan), .fault_irq_req(fault_irq_req));
    task tally_and_finish;
        begin
            $display("errors %0d checks %0d", num_errors, samples_checked);
            if (num_errors == 0 && samples_checked > 0)
                $display("Simulation passed");
            else
                $display("Simulation failed");
            $finish;
        end
    endtask
    task check(input [15:0] got, input [15:0] exp);
        begin
            samples_checked = samples_checked + 1;
            if (got !== exp) begin
                num_errors = num_errors + 1;
                $display("[ERR] %0t got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task wr(input [7:0] wa, input [15:0] d);
        begin
            @(posedge ref_clk) #1 wr_en = 1;
            addr = wa;
            wr_data = d;
            @(posedge ref_clk) #1 wr_en = 0;
        end
    endtask
    task rd(input [7:0] ra, input [15:0] e);
        begin
            @(posedge ref_clk) #1 rd_en = 1;
            addr = ra;
            @(posedge ref_clk) #1 rd_en = 0;
            check(rd_data, e);
            check({15'h0000, rd_hit}, {15'h0000, ra == 8'h10 || ra == 8'h12});
        end
    endtask
    // Events last one cycle, so only the sticky flag can keep the request up
    task pulse(input [12:0] e, input [5:0] c, input irq);
        begin
            @(posedge ref_clk) #1 ev = e;
            chan = c;
            @(posedge ref_clk) #1 ev = 0;
            chan = 0;
            check({15'h0000, fault_irq_req}, {15'h0000, irq});
        end
    endtask
    initial begin
        #20000;
        num_errors = num_errors + 1;
        tally_and_finish;
    end
    initial begin
        repeat (8) @(posedge ref_clk);
        #1 sys_rst = 0;
        rd(8'h10, 16'h0000);
        rd(8'h12, 16'h0000);
        rd(8'h14, 16'h0000);
        for (k = 0; k < 10; k = k + 1) begin
            pos = (k < 8) ? 2 * k + 1 : 30 - 2 * k;
            a = (k < 8) ? 8'h10 : 8'h12;
            m = 16'h0001 << pos;
            pulse(13'h0001 << k, 6'h00, k != 0);
            rd(a, m);
            wr(a, m);
            rd(a, m);
            wr(a, m >> 1);
            rd(a, m);
            wr(a, m | (m >> 1));
            rd(a, 16'h0000);
            check({15'h0000, fault_irq_req}, 16'h0000);
        end
        pulse(13'h1c00, 6'h3f, 1'b1);
        rd(8'h12, 16'h05ff);
        wr(8'h12, 16'h81ff);
        rd(8'h12, 16'h05ff);
        wr(8'h14, 16'h0600);
        rd(8'h12, 16'h05ff);
        wr(8'h12, 16'h0600);
        rd(8'h12, 16'h0000);
        check({15'h0000, fault_irq_req}, 16'h0000);
        // Event still high at the clearing write: the set must win
        @(posedge ref_clk) #1 ev = 13'h0080;
        wr(8'h10, 16'hc000);
        ev = 0;
        rd(8'h10, 16'h8000);
        wr(8'h10, 16'hc000);
        rd(8'h10, 16'h0000);
        // A second reset in mid-run must wipe every flag
        pulse(13'h0300, 6'h01, 1'b1);
        @(posedge ref_clk) #1 sys_rst = 1;
        repeat (2) @(posedge ref_clk);
        #1 sys_rst = 0;
        check({15'h0000, fault_irq_req}, 16'h0000);
        rd(8'h10, 16'h0000);
        rd(8'h12, 16'h0000);
        tally_and_finish;
    end
endmodule // testbench
bind bfsr_regs bfsr_asserts #(.CHANS(CHANS)) u_chk (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .rd_en(rd_en),
    .addr(addr),
    .rd_data(rd_data),
    .rd_hit(rd_hit),
    .thermal_trip_evt(thermal_trip_evt),
    .channel_fault_evt(channel_fault_evt),
    .fault_irq_req(fault_irq_req)
);
`default_nettype wire
